// ---- verilog/gpio_cde_pkg.sv ----
// Shared register map, pin positions, reset values and carrier types for the port C/D/E block.
`default_nettype none
package gpio_cde_pkg;
    // Register indices; the APB byte address is four times the index.
    localparam int ADDR_W = 12;
    localparam logic [9:0] IDX_PORT_C_DATA = 10'h002;
    localparam logic [9:0] IDX_PORT_D_DATA = 10'h003;
    localparam logic [9:0] IDX_PORT_E_DATA = 10'h008;
    localparam logic [9:0] IDX_PORT_C_DIR = 10'h010;
    localparam logic [9:0] IDX_PORT_D_DIR = 10'h011;
    localparam logic [9:0] IDX_PORT_E_DIR = 10'h012;
    localparam logic [9:0] IDX_PORT_D_PUE = 10'h013;
    // Field positions.
    localparam int CLK_OUT_BIT = 7;
    localparam int PC_CLK_PIN = 2;
    localparam int PD_TA_CLK_PIN = 6;
    localparam int PD_TB_CLK_PIN = 4;
    localparam int PE_SCK_PIN = 7;
    localparam int PE_MOSI_PIN = 6;
    localparam int PE_MISO_PIN = 5;
    localparam int PE_SS_PIN = 4;
    localparam int PE_TCH0_PIN = 2;
    localparam int PE_RX_PIN = 1;
    localparam int PE_TX_PIN = 0;
    // Prescaler code that selects the external timer clock.
    localparam logic [2:0] PRESCALE_EXT = 3'h7;
    // Reset values of control registers.
    localparam logic [5:0] PC_DIR_RESET = 6'h00;
    localparam logic [7:0] PD_DIR_RESET = 8'h00;
    localparam logic [7:0] PE_DIR_RESET = 8'h00;
    localparam logic [7:0] PD_PUE_RESET = 8'h00;
    localparam logic CLK_OUT_RESET = 1'b0;

    typedef struct packed {
        logic on;
        logic master;
        logic sck_out;
        logic mosi_out;
        logic miso_out;
    } spi_drive_t;

    typedef struct packed {
        logic sck_in;
        logic mosi_in;
        logic miso_in;
        logic ss_in;
    } spi_sense_t;

    typedef struct packed {
        logic [1:0] edge_level_select;
        logic out;
        logic oe;
    } timer_ch_drive_t;

    typedef struct packed {
        logic on;
        logic tx_out;
    } sci_drive_t;

    typedef struct packed {
        logic [5:0] pc_latch;
        logic [7:0] pd_latch;
        logic [7:0] pe_latch;
        logic [5:0] pc_dir;
        logic clk_out;
        logic [7:0] pd_dir;
        logic [7:0] pe_dir;
        logic [7:0] pd_pue;
        logic [21:0] pin_meta;
        logic [21:0] pin_sync;
        logic [31:0] rdata;
        logic err;
    } state_t;
endpackage
`default_nettype wire

// ---- verilog/gpio_ports_c_d_e.sv ----
// APB-mapped general-purpose I/O for ports C, D and E with peripheral pin sharing.
`default_nettype none
module gpio_ports_c_d_e (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [gpio_cde_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [5:0] pc_in,
    output logic [5:0] pc_out,
    output logic [5:0] pc_oe,
    input wire logic [7:0] pd_in,
    output logic [7:0] pd_out,
    output logic [7:0] pd_oe,
    output logic [7:0] pd_pullup,
    input wire logic [7:0] pe_in,
    output logic [7:0] pe_out,
    output logic [7:0] pe_oe,
    input wire logic [2:0] timer_a_prescaler_select,
    input wire logic [2:0] timer_b_prescaler_select,
    output logic timer_a_ext_clock,
    output logic timer_b_ext_clock,
    input wire gpio_cde_pkg::spi_drive_t spi_drive,
    output gpio_cde_pkg::spi_sense_t spi_sense,
    input wire gpio_cde_pkg::timer_ch_drive_t [1:0] timer_a_ch_drive,
    output logic [1:0] timer_a_ch_in,
    input wire gpio_cde_pkg::sci_drive_t sci_drive,
    output logic sci_rx_in
);
    import gpio_cde_pkg::*;

    state_t state_q;
    state_t state_d;
    logic setup;
    logic access_wr;
    logic [7:0] pe_own;
    logic [7:0] pe_per_oe;
    logic [7:0] pe_per_out;
    logic [5:0] pc_pin;
    logic [7:0] pd_pin;
    logic [7:0] pe_pin;
    logic [5:0] pc_read;
    logic [7:0] pc_mux;

    // Picks the latch on output pins and the pin level on input pins.
    function automatic logic [7:0] pin_or_latch(input logic [7:0] dir, input logic [7:0] latch,
                                                input logic [7:0] pin);
        pin_or_latch = (dir & latch) | (~dir & pin);
    endfunction

    // Word-aligned address match against a register index.
    function automatic logic hits(input logic [ADDR_W-1:0] addr, input logic [9:0] idx);
        hits = (addr[1:0] == 2'h0) && (addr[ADDR_W-1:2] == idx);
    endfunction

    assign setup = psel && !penable;
    assign access_wr = psel && penable && pwrite;
    assign pc_pin = state_q.pin_sync[21:16];
    assign pd_pin = state_q.pin_sync[15:8];
    assign pe_pin = state_q.pin_sync[7:0];

    // Pin 2 reads as zero while it carries the system clock.
    always_comb begin
        pc_mux = pin_or_latch({2'h0, state_q.pc_dir}, {2'h0, state_q.pc_latch}, {2'h0, pc_pin});
        pc_read = pc_mux[5:0];
        if (state_q.clk_out) begin
            pc_read[PC_CLK_PIN] = 1'b0;
        end
    end

    // Port E ownership by the SPI, timer A channels and the serial interface.
    always_comb begin
        pe_own = 8'h00;
        pe_per_oe = 8'h00;
        pe_per_out = 8'h00;
        pe_own[PE_SCK_PIN] = spi_drive.on;
        pe_per_oe[PE_SCK_PIN] = spi_drive.master;
        pe_per_out[PE_SCK_PIN] = spi_drive.sck_out;
        pe_own[PE_MOSI_PIN] = spi_drive.on;
        pe_per_oe[PE_MOSI_PIN] = spi_drive.master;
        pe_per_out[PE_MOSI_PIN] = spi_drive.mosi_out;
        pe_own[PE_MISO_PIN] = spi_drive.on;
        pe_per_oe[PE_MISO_PIN] = !spi_drive.master;
        pe_per_out[PE_MISO_PIN] = spi_drive.miso_out;
        pe_own[PE_SS_PIN] = spi_drive.on && !spi_drive.master;
        for (int ch = 0; ch < 2; ch++) begin
            pe_own[PE_TCH0_PIN + ch] = timer_a_ch_drive[ch].edge_level_select != 2'h0;
            pe_per_oe[PE_TCH0_PIN + ch] = timer_a_ch_drive[ch].oe;
            pe_per_out[PE_TCH0_PIN + ch] = timer_a_ch_drive[ch].out;
        end
        pe_own[PE_RX_PIN] = sci_drive.on;
        pe_own[PE_TX_PIN] = sci_drive.on;
        pe_per_oe[PE_TX_PIN] = 1'b1;
        pe_per_out[PE_TX_PIN] = sci_drive.tx_out;
    end

    // Pin drive; a claimed pin follows its peripheral instead of the port registers.
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_pe_pin
            assign pe_oe[gi] = pe_own[gi] ? pe_per_oe[gi] : state_q.pe_dir[gi];
            assign pe_out[gi] = pe_own[gi] ? pe_per_out[gi] : state_q.pe_latch[gi];
        end
        for (gi = 0; gi < 6; gi++) begin : g_pc_pin
            if (gi == PC_CLK_PIN) begin : g_clk
                assign pc_oe[gi] = state_q.clk_out | state_q.pc_dir[gi];
                assign pc_out[gi] = state_q.clk_out ? pclk : state_q.pc_latch[gi];
            end else begin : g_io
                assign pc_oe[gi] = state_q.pc_dir[gi];
                assign pc_out[gi] = state_q.pc_latch[gi];
            end
        end
    endgenerate

    assign pd_oe = state_q.pd_dir;
    assign pd_out = state_q.pd_latch;
    assign pd_pullup = state_q.pd_pue & ~state_q.pd_dir;

    // Peripheral inputs see the synchronised pin level; idle levels apply when not claimed.
    assign timer_a_ext_clock = (timer_a_prescaler_select == PRESCALE_EXT) && pd_pin[PD_TA_CLK_PIN];
    assign timer_b_ext_clock = (timer_b_prescaler_select == PRESCALE_EXT) && pd_pin[PD_TB_CLK_PIN];
    assign spi_sense.sck_in = pe_own[PE_SCK_PIN] && pe_pin[PE_SCK_PIN];
    assign spi_sense.mosi_in = pe_own[PE_MOSI_PIN] && pe_pin[PE_MOSI_PIN];
    assign spi_sense.miso_in = pe_own[PE_MISO_PIN] && pe_pin[PE_MISO_PIN];
    assign spi_sense.ss_in = !pe_own[PE_SS_PIN] || pe_pin[PE_SS_PIN];
    assign timer_a_ch_in = pe_pin[PE_TCH0_PIN + 1:PE_TCH0_PIN] & pe_own[PE_TCH0_PIN + 1:PE_TCH0_PIN];
    assign sci_rx_in = !pe_own[PE_RX_PIN] || pe_pin[PE_RX_PIN];

    // The slave answers with no wait states; read data is captured in the setup cycle.
    assign pready = 1'b1;
    assign prdata = state_q.rdata;
    assign pslverr = psel && penable && state_q.err;

    always_comb begin
        state_d = state_q;
        state_d.pin_meta = {pc_in, pd_in, pe_in};
        state_d.pin_sync = state_q.pin_meta;
        if (setup) begin
            state_d.rdata = 32'h0000_0000;
            state_d.err = 1'b0;
            if (hits(paddr, IDX_PORT_C_DATA)) begin
                state_d.rdata[5:0] = pc_read;
            end else if (hits(paddr, IDX_PORT_D_DATA)) begin
                state_d.rdata[7:0] = pin_or_latch(state_q.pd_dir, state_q.pd_latch, pd_pin);
            end else if (hits(paddr, IDX_PORT_E_DATA)) begin
                state_d.rdata[7:0] = pin_or_latch(state_q.pe_dir, state_q.pe_latch, pe_pin);
            end else if (hits(paddr, IDX_PORT_C_DIR)) begin
                state_d.rdata[CLK_OUT_BIT] = state_q.clk_out;
                state_d.rdata[5:0] = state_q.pc_dir;
            end else if (hits(paddr, IDX_PORT_D_DIR)) begin
                state_d.rdata[7:0] = state_q.pd_dir;
            end else if (hits(paddr, IDX_PORT_E_DIR)) begin
                state_d.rdata[7:0] = state_q.pe_dir;
            end else if (hits(paddr, IDX_PORT_D_PUE)) begin
                state_d.rdata[7:0] = state_q.pd_pue;
            end else begin
                state_d.err = 1'b1;
            end
        end
        if (access_wr) begin
            if (hits(paddr, IDX_PORT_C_DATA)) begin
                state_d.pc_latch = pwdata[5:0];
                if (state_q.clk_out) begin
                    state_d.pc_latch[PC_CLK_PIN] = state_q.pc_latch[PC_CLK_PIN];
                end
            end
            if (hits(paddr, IDX_PORT_D_DATA)) begin
                state_d.pd_latch = pwdata[7:0];
            end
            if (hits(paddr, IDX_PORT_E_DATA)) begin
                state_d.pe_latch = pwdata[7:0];
            end
            if (hits(paddr, IDX_PORT_C_DIR)) begin
                state_d.clk_out = pwdata[CLK_OUT_BIT];
                state_d.pc_dir = pwdata[5:0];
            end
            if (hits(paddr, IDX_PORT_D_DIR)) begin
                state_d.pd_dir = pwdata[7:0];
            end
            if (hits(paddr, IDX_PORT_E_DIR)) begin
                state_d.pe_dir = pwdata[7:0];
            end
            if (hits(paddr, IDX_PORT_D_PUE)) begin
                state_d.pd_pue = pwdata[7:0];
            end
        end
    end

    // Data latches carry no reset so their contents survive it.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q.pc_dir <= PC_DIR_RESET;
            state_q.clk_out <= CLK_OUT_RESET;
            state_q.pd_dir <= PD_DIR_RESET;
            state_q.pe_dir <= PE_DIR_RESET;
            state_q.pd_pue <= PD_PUE_RESET;
            state_q.pin_meta <= 22'h000000;
            state_q.pin_sync <= 22'h000000;
            state_q.rdata <= 32'h0000_0000;
            state_q.err <= 1'b0;
        end else begin
            state_q <= state_d;
        end
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    property p_pc_read;
        setup && !pwrite && hits(paddr, IDX_PORT_C_DATA) && !state_q.clk_out
            |=> prdata[5:0] == (($past(state_q.pc_dir) & $past(state_q.pc_latch))
                | (~$past(state_q.pc_dir) & $past(pc_pin)));
    endproperty
    a_pc_read: assert property (p_pc_read) else $error("Port C read mismatches direction mux.");

    property p_latch_write;
        access_wr && hits(paddr, IDX_PORT_D_DATA) |=> state_q.pd_latch == $past(pwdata[7:0]);
    endproperty
    a_latch_write: assert property (p_latch_write) else $error("Port D latch missed a write.");

    property p_pc2_locked;
        state_q.clk_out && access_wr && hits(paddr, IDX_PORT_C_DATA)
            |=> $stable(state_q.pc_latch[PC_CLK_PIN]);
    endproperty
    a_pc2_locked: assert property (p_pc2_locked) else $error("Port C pin 2 latch changed under clock out.");

    property p_pc2_reads_zero;
        setup && hits(paddr, IDX_PORT_C_DATA) && state_q.clk_out |=> prdata[PC_CLK_PIN] == 1'b0;
    endproperty
    a_pc2_reads_zero: assert property (p_pc2_reads_zero) else $error("Port C pin 2 not zero on read.");

    property p_clk_out;
        state_q.clk_out |-> pc_oe[PC_CLK_PIN];
    endproperty
    a_clk_out: assert property (p_clk_out) else $error("Clock output pin not driven.");

    property p_pd_dir;
        access_wr && hits(paddr, IDX_PORT_D_DIR) |=> pd_oe == $past(pwdata[7:0]) [*2];
    endproperty
    a_pd_dir: assert property (p_pd_dir) else $error("Port D output enables do not follow direction.");

    property p_pullup;
        access_wr && hits(paddr, IDX_PORT_D_PUE) |=> pd_pullup == ($past(pwdata[7:0]) & ~pd_oe);
    endproperty
    a_pullup: assert property (p_pullup) else $error("Pullup does not follow enable and direction.");

    property p_ta_clk;
        timer_a_prescaler_select != PRESCALE_EXT |-> !timer_a_ext_clock;
    endproperty
    a_ta_clk: assert property (p_ta_clk) else $error("Timer A external clock without selection.");

    property p_tb_clk;
        timer_b_prescaler_select == PRESCALE_EXT |-> timer_b_ext_clock == pd_pin[PD_TB_CLK_PIN];
    endproperty
    a_tb_clk: assert property (p_tb_clk) else $error("Timer B external clock not from pin 4.");

    property p_ss_input;
        spi_drive.on && !spi_drive.master |-> !pe_oe[PE_SS_PIN];
    endproperty
    a_ss_input: assert property (p_ss_input) else $error("Slave select pin driven in slave mode.");

    property p_sci_tx;
        sci_drive.on |-> pe_oe[PE_TX_PIN] && pe_out[PE_TX_PIN] == sci_drive.tx_out;
    endproperty
    a_sci_tx: assert property (p_sci_tx) else $error("Transmit pin not owned by serial interface.");

    property p_pe_read;
        setup && !pwrite && hits(paddr, IDX_PORT_E_DATA) |=> prdata[7:0] == ((~$past(state_q.pe_dir)
            & $past(pe_pin)) | ($past(state_q.pe_dir) & $past(state_q.pe_latch)));
    endproperty
    a_pe_read: assert property (p_pe_read) else $error("Port E read not chosen by direction.");

    property p_pd_read;
        setup && !pwrite && hits(paddr, IDX_PORT_D_DATA) |=> prdata[7:0] == (($past(state_q.pd_dir)
            & $past(state_q.pd_latch)) | (~$past(state_q.pd_dir) & $past(pd_pin)));
    endproperty
    a_pd_read: assert property (p_pd_read) else $error("Port D read not chosen by direction.");

    property p_pullup_off;
        (pd_pullup & pd_oe) == 8'h00;
    endproperty
    a_pullup_off: assert property (p_pullup_off) else $error("Pullup left on an output pin.");

    property p_sck_pin;
        spi_drive.on |-> pe_oe[PE_SCK_PIN] == spi_drive.master;
    endproperty
    a_sck_pin: assert property (p_sck_pin) else $error("SPI clock pin direction wrong.");

    property p_mosi_miso;
        spi_drive.on |-> pe_oe[PE_MOSI_PIN] == spi_drive.master && pe_oe[PE_MISO_PIN] == !spi_drive.master;
    endproperty
    a_mosi_miso: assert property (p_mosi_miso) else $error("SPI data pin direction wrong.");

    property p_ss_gpio;
        !spi_drive.on || spi_drive.master |-> pe_oe[PE_SS_PIN] == state_q.pe_dir[PE_SS_PIN];
    endproperty
    a_ss_gpio: assert property (p_ss_gpio) else $error("Slave select pin not general purpose.");

    property p_tch_own;
        timer_a_ch_drive[1].edge_level_select != 2'h0 |-> pe_oe[PE_TCH0_PIN + 1] == timer_a_ch_drive[1].oe;
    endproperty
    a_tch_own: assert property (p_tch_own) else $error("Timer channel pin not driven by timer.");

    property p_tx_gpio;
        !sci_drive.on |-> pe_oe[PE_TX_PIN] == state_q.pe_dir[PE_TX_PIN];
    endproperty
    a_tx_gpio: assert property (p_tx_gpio) else $error("Transmit pin not general purpose.");

    property p_rx_in;
        sci_drive.on |-> sci_rx_in == pe_pin[PE_RX_PIN];
    endproperty
    a_rx_in: assert property (p_rx_in) else $error("Receive input not fed from pin 1.");

    c_clk_out: cover property (access_wr && hits(paddr, IDX_PORT_C_DIR) && pwdata[CLK_OUT_BIT]);
    c_spi_slave: cover property (spi_drive.on && !spi_drive.master && state_q.pe_dir[PE_SS_PIN]);
    c_unmapped: cover property (pslverr);
    c_ta_ext: cover property (timer_a_ext_clock);
    c_pe_timer: cover property (pe_own[PE_TCH0_PIN + 1]);
endmodule // gpio_ports_c_d_e
`default_nettype wire

// ---- sim/pin_world.sv ----
// External pin model for ports C, D and E: outside drivers, pullups and a floating pattern.
`default_nettype none
module pin_world (
    input wire logic pclk,
    input wire logic ext_en,
    input wire logic [5:0] ext_c,
    input wire logic [7:0] ext_d,
    input wire logic [7:0] ext_e,
    input wire logic [5:0] pc_out,
    input wire logic [5:0] pc_oe,
    input wire logic [7:0] pd_out,
    input wire logic [7:0] pd_oe,
    input wire logic [7:0] pd_pullup,
    input wire logic [7:0] pe_out,
    input wire logic [7:0] pe_oe,
    output logic [5:0] pc_in,
    output logic [7:0] pd_in,
    output logic [7:0] pe_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // A released pin with no pullup shows a pattern that changes every cycle.
    logic flip = 1'b0;
    always @(posedge pclk) begin
        flip <= ~flip;
    end
    // Each pin level is fed back so that a claiming peripheral sees it.
    assign pc_in = (pc_oe & pc_out) | (~pc_oe & (ext_en ? ext_c : {6{flip}}));
    assign pe_in = (pe_oe & pe_out) | (~pe_oe & (ext_en ? ext_e : {8{flip}}));
    // A connected pullup holds a released input high.
    assign pd_in = (pd_oe & pd_out) | (~pd_oe & (ext_en ? ext_d : (pd_pullup | {8{flip}})));
endmodule // pin_world
`default_nettype wire

// ---- sim/tb_gpio_ports_c_d_e.sv ----
// Self-checking bench for the port C, D and E block.
`default_nettype none
module tb_gpio_ports_c_d_e;
    timeunit 1ns;
    timeprecision 1ps;
    import gpio_cde_pkg::*;
    typedef struct packed {
        logic [4:0] spi;
        logic [7:0] ch;
        logic [1:0] async_serial_if;
        logic [7:0] dir;
        logic [7:0] oe;
        logic [7:0] out;
    } row_t;
    row_t rows [4] = '{
        '{5'h1A, 8'h00, 2'h0, 8'h10, 8'hD0, 8'h50},
        '{5'h00, 8'h00, 2'h0, 8'hFF, 8'hFF, 8'hFF},
        '{5'h00, 8'hB0, 2'h3, 8'h00, 8'h09, 8'h09},
        '{5'h10, 8'h07, 2'h2, 8'h10, 8'h25, 8'h04}
    };
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [31:0] prdata;
    logic pready, pslverr, err, ta_clk, tb_clk, rx_in;
    logic ext_en = 1'b1;
    logic [5:0] ext_c = 6'h00;
    logic [7:0] ext_d = 8'h00;
    logic [7:0] ext_e = 8'h00;
    logic [5:0] pc_in, pc_out, pc_oe;
    logic [7:0] pd_in, pd_out, pd_oe, pd_pullup, pe_in, pe_out, pe_oe;
    logic [2:0] ta_ps = 3'h0;
    logic [2:0] tb_ps = 3'h0;
    logic [1:0] ch_in;
    spi_drive_t spi_drive = '0;
    spi_sense_t spi_sense;
    timer_ch_drive_t [1:0] ta_ch = '0;
    sci_drive_t async_serial_if = '0;
    int checked = 0;
    int miscompares = 0;
    int cycles = 0;

    always #5 pclk = ~pclk;

    gpio_ports_c_d_e dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pc_in(pc_in), .pc_out(pc_out), .pc_oe(pc_oe), .pd_in(pd_in), .pd_out(pd_out), .pd_oe(pd_oe),
        .pd_pullup(pd_pullup), .pe_in(pe_in), .pe_out(pe_out), .pe_oe(pe_oe),
        .timer_a_prescaler_select(ta_ps), .timer_b_prescaler_select(tb_ps), .timer_a_ext_clock(ta_clk),
        .timer_b_ext_clock(tb_clk), .spi_drive(spi_drive), .spi_sense(spi_sense), .timer_a_ch_drive(ta_ch),
        .timer_a_ch_in(ch_in), .sci_drive(async_serial_if), .sci_rx_in(rx_in));

    pin_world world (.pclk(pclk), .ext_en(ext_en), .ext_c(ext_c), .ext_d(ext_d), .ext_e(ext_e),
        .pc_out(pc_out), .pc_oe(pc_oe), .pd_out(pd_out), .pd_oe(pd_oe), .pd_pullup(pd_pullup),
        .pe_out(pe_out), .pe_oe(pe_oe), .pc_in(pc_in), .pd_in(pd_in), .pe_in(pe_in));

    task automatic results();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    always @(posedge pclk) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            results();
        end
    end

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One APB transfer, entered and left just after a rising edge, with an idle cycle after it.
    task automatic apb(input logic wr, input logic [9:0] idx, input logic [31:0] wd, output logic [31:0] rd);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [9:0] idx, input logic [31:0] d);
        logic [31:0] v;
        apb(1'b1, idx, d, v);
    endtask

    task automatic rd(input logic [9:0] idx, input logic [31:0] exp, input string what);
        logic [31:0] v;
        apb(1'b0, idx, 32'h0, v);
        chk(what, v, exp);
    endtask

    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(IDX_PORT_C_DIR, 32'h0, "c_dir");
        rd(IDX_PORT_D_DIR, 32'h0, "d_dir");
        chk("slverr_ok", err, 1'b0);
        rd(10'h3FF, 32'h0, "unmapped");
        chk("slverr", err, 1'b1);
        $display("reset values done");
        ext_d <= 8'h3C;
        wr(IDX_PORT_D_DATA, 32'hA5);
        wr(IDX_PORT_D_DIR, 32'hF0);
        repeat (3) @(posedge pclk);
        rd(IDX_PORT_D_DATA, 32'hAC, "d_mix");
        chk("pd_oe", pd_oe, 8'hF0);
        wr(IDX_PORT_D_DATA, 32'h5A);
        rd(IDX_PORT_D_DATA, 32'h5C, "d_wr_in");
        wr(IDX_PORT_D_PUE, 32'hFF);
        ext_en <= 1'b0;
        repeat (3) @(posedge pclk);
        chk("pullup", pd_pullup, 8'h0F);
        rd(IDX_PORT_D_DATA, 32'h5F, "d_pull");
        wr(IDX_PORT_D_PUE, 32'h05);
        chk("pullup2", pd_pullup, 8'h05);
        ext_en <= 1'b1;
        wr(IDX_PORT_E_DATA, 32'hFF);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk("pd_keep", pd_out, 8'h5A);
        chk("pe_keep", pe_out, 8'hFF);
        chk("pd_oe_rst", pd_oe, 8'h00);
        $display("port d done");
        ext_e <= 8'hC0;
        foreach (rows[i]) begin
            spi_drive <= rows[i].spi;
            ta_ch <= rows[i].ch;
            async_serial_if <= rows[i].async_serial_if;
            wr(IDX_PORT_E_DIR, {24'h0, rows[i].dir});
            chk("pe_oe", pe_oe, rows[i].oe);
            chk("pe_out", pe_out & rows[i].oe, rows[i].out);
        end
        repeat (3) @(posedge pclk);
        chk("spi_sense", spi_sense, 4'hC);
        chk("rx_in", rx_in, 1'b0);
        chk("ch_in", ch_in, 2'h1);
        rd(IDX_PORT_E_DATA, 32'hD4, "e_mix");
        $display("port e done");
        wr(IDX_PORT_C_DATA, 32'h3F);
        wr(IDX_PORT_C_DIR, 32'h07);
        repeat (3) @(posedge pclk);
        rd(IDX_PORT_C_DATA, 32'h07, "c_mix");
        wr(IDX_PORT_C_DIR, 32'h87);
        rd(IDX_PORT_C_DIR, 32'h87, "c_dir2");
        rd(IDX_PORT_C_DATA, 32'h03, "c_clk");
        chk("pc_oe", pc_oe, 6'h07);
        #2;
        chk("clk_hi", pc_out[2], 1'b1);
        @(negedge pclk);
        #2;
        chk("clk_lo", pc_out[2], 1'b0);
        @(posedge pclk);
        wr(IDX_PORT_C_DATA, 32'h00);
        wr(IDX_PORT_C_DIR, 32'h07);
        rd(IDX_PORT_C_DATA, 32'h04, "c_ign");
        $display("port c done");
        ext_d <= 8'h40;
        wr(IDX_PORT_D_DIR, 32'h00);
        ta_ps <= PRESCALE_EXT;
        tb_ps <= PRESCALE_EXT;
        repeat (3) @(posedge pclk);
        chk("ta_clk", ta_clk, 1'b1);
        chk("tb_clk", tb_clk, 1'b0);
        ext_d <= 8'h10;
        repeat (3) @(posedge pclk);
        chk("ta_clk2", ta_clk, 1'b0);
        chk("tb_clk2", tb_clk, 1'b1);
        tb_ps <= 3'h6;
        repeat (3) @(posedge pclk);
        chk("tb_off", tb_clk, 1'b0);
        $display("timer clocks done");
        results();
    end
endmodule // tb_gpio_ports_c_d_e
`default_nettype wire
